// ---- hdl/bsp_chain.sv ----
`timescale 1ns/10ps
`include "bsp_consts.svh"

// ==========================================================================
// Boundary chain: one capture/shift stage and one update latch per cell.
module bsp_chain (
  input wire logic sys_clk,
  input wire logic scan_rst,
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  input wire logic tdi,
  input wire logic [`BSP_CHAIN_LEN-1:0] par_in,
  output logic so,
  output logic [`BSP_CHAIN_LEN-1:0] upd_q
);
  import bsp_pkg::*;

  // Shift stages and their next values.
  logic [`BSP_CHAIN_LEN-1:0] sh_q;
  logic [`BSP_CHAIN_LEN-1:0] sh_d;
  // Update latches' next values.
  logic [`BSP_CHAIN_LEN-1:0] upd_d;

  // ========================================================================
  // Per-cell next values.
  genvar i;
  generate
    for (i = 0; i < `BSP_CHAIN_LEN; i = i + 1) begin : g_cell
      // Data enters at the top cell and walks down toward cell 0.
      logic from_up;
      if (i == `BSP_CHAIN_LEN - 1) begin : g_top
        assign from_up = tdi;
      end else begin : g_mid
        assign from_up = sh_q[i+1];
      end
      always_comb begin
        sh_d[i] = sh_q[i];
        if (capture) begin
          sh_d[i] = par_in[i];
        end else if (shift) begin
          sh_d[i] = from_up;
        end
        upd_d[i] = update ? sh_q[i] : upd_q[i];
      end
    end
  endgenerate

  // Registers; update latches clear so every enable cell starts disabled.
  always_ff @(posedge sys_clk) begin
    if (scan_rst) begin
      sh_q <= '0;
      upd_q <= '0;
    end else begin
      sh_q <= sh_d;
      upd_q <= upd_d;
    end
  end

  // Serial output is the lowest cell.
  assign so = sh_q[0];

endmodule : bsp_chain

// ---- hdl/bsp_consts.svh ----
`ifndef BSP_CONSTS_SVH
`define BSP_CONSTS_SVH

// ==========================================================================
// Scan chain geometry.
// Number of cells in the boundary chain; cell 0 leaves first.
`define BSP_CHAIN_LEN 118
// Width of the instruction register.
`define BSP_IR_LEN 3

// ==========================================================================
// Instruction values.
// Loaded by test reset, so the scan logic starts out in bypass.
`define BSP_IR_RESET 3'h7
// Fixed pattern captured into the instruction shifter (low bits 01).
`define BSP_IR_CAPTURE 3'h1

// ==========================================================================
// Pin sampling.
// Number of sampled pin signals.
`define BSP_NPIN 7
// Bit positions of the sampled pins in the synchroniser vector.
`define BSP_PIN_TCK 0
`define BSP_PIN_TMS 1
`define BSP_PIN_TMS_DRV 2
`define BSP_PIN_TDI 3
`define BSP_PIN_TDI_DRV 4
`define BSP_PIN_TRST 5
`define BSP_PIN_TRST_DRV 6

`endif

// ---- hdl/bsp_pkg.sv ----
// ==========================================================================
// Types shared by the test port files.
package bsp_pkg;

  // The sixteen controller states of the test access port.
  typedef enum logic [3:0] {
    BSP_TLR,
    BSP_RTI,
    BSP_SEL_DR,
    BSP_CAP_DR,
    BSP_SHF_DR,
    BSP_EX1_DR,
    BSP_PAU_DR,
    BSP_EX2_DR,
    BSP_UPD_DR,
    BSP_SEL_IR,
    BSP_CAP_IR,
    BSP_SHF_IR,
    BSP_EX1_IR,
    BSP_PAU_IR,
    BSP_EX2_IR,
    BSP_UPD_IR
  } bsp_state_t;

endpackage : bsp_pkg

// ---- hdl/bsp_tap.sv ----
`timescale 1ns/10ps
`include "bsp_consts.svh"

module bsp_tap (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck_pin,
  input wire logic tms_pin,
  input wire logic tms_drv,
  input wire logic tdi_pin,
  input wire logic tdi_drv,
  input wire logic trst_n_pin,
  input wire logic trst_n_drv,
  output logic tdo_o,
  output logic tdo_oe,
  input wire logic [`BSP_CHAIN_LEN-1:0] bsr_pin_in,
  output logic [`BSP_CHAIN_LEN-1:0] bsr_cell_out,
  output logic extest_on
);
  import bsp_pkg::*;

  // ========================================================================
  // Pin synchronisers.
  // First stage, read only by the second stage.
  logic [`BSP_NPIN-1:0] meta_q;
  // Second stage, safe to use.
  logic [`BSP_NPIN-1:0] pin_q;
  // Previous test clock level, for edge detection.
  logic tck_prev_q;

  // Two flops per pin; the pins belong to no clock of ours.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q <= '0;
      pin_q <= '0;
      tck_prev_q <= 1'b0;
    end else begin
      meta_q <= {trst_n_drv, trst_n_pin, tdi_drv, tdi_pin, tms_drv, tms_pin,
                 tck_pin};
      pin_q <= meta_q;
      tck_prev_q <= pin_q[`BSP_PIN_TCK];
    end
  end

  // Effective pin levels with internal pull-ups applied.
  logic tms;
  logic tdi;
  logic trst_n;
  // Test clock edges found by the system clock.
  logic tck_rise;
  logic tck_fall;
  // Scan logic reset, from system reset or test reset.
  logic scan_rst;

  assign tms = pin_q[`BSP_PIN_TMS_DRV] ? pin_q[`BSP_PIN_TMS] : 1'b1;
  assign tdi = pin_q[`BSP_PIN_TDI_DRV] ? pin_q[`BSP_PIN_TDI] : 1'b1;
  assign trst_n = pin_q[`BSP_PIN_TRST_DRV] ? pin_q[`BSP_PIN_TRST] : 1'b1;
  assign tck_rise = pin_q[`BSP_PIN_TCK] & ~tck_prev_q;
  assign tck_fall = ~pin_q[`BSP_PIN_TCK] & tck_prev_q;
  assign scan_rst = rst | ~trst_n;

  // ========================================================================
  // Controller state machine.
  bsp_state_t st_q;
  bsp_state_t st_d;
  // Next state as the mode select dictates.
  bsp_state_t st_nx;

  // Standard transitions; mode select high walks toward reset.
  // sixteen-state sequence
  always_comb begin
    case (st_q)
      BSP_TLR: st_nx = tms ? BSP_TLR : BSP_RTI;
      BSP_RTI: st_nx = tms ? BSP_SEL_DR : BSP_RTI;
      BSP_SEL_DR: st_nx = tms ? BSP_SEL_IR : BSP_CAP_DR;
      BSP_CAP_DR: st_nx = tms ? BSP_EX1_DR : BSP_SHF_DR;
      BSP_SHF_DR: st_nx = tms ? BSP_EX1_DR : BSP_SHF_DR;
      BSP_EX1_DR: st_nx = tms ? BSP_UPD_DR : BSP_PAU_DR;
      BSP_PAU_DR: st_nx = tms ? BSP_EX2_DR : BSP_PAU_DR;
      BSP_EX2_DR: st_nx = tms ? BSP_UPD_DR : BSP_SHF_DR;
      BSP_UPD_DR: st_nx = tms ? BSP_SEL_DR : BSP_RTI;
      BSP_SEL_IR: st_nx = tms ? BSP_TLR : BSP_CAP_IR;
      BSP_CAP_IR: st_nx = tms ? BSP_EX1_IR : BSP_SHF_IR;
      BSP_SHF_IR: st_nx = tms ? BSP_EX1_IR : BSP_SHF_IR;
      BSP_EX1_IR: st_nx = tms ? BSP_UPD_IR : BSP_PAU_IR;
      BSP_PAU_IR: st_nx = tms ? BSP_EX2_IR : BSP_PAU_IR;
      BSP_EX2_IR: st_nx = tms ? BSP_UPD_IR : BSP_SHF_IR;
      BSP_UPD_IR: st_nx = tms ? BSP_SEL_DR : BSP_RTI;
      default: st_nx = BSP_TLR;
    endcase
  end

  // State only moves on a test clock rise.
  // sample mode select
  always_comb begin
    st_d = tck_rise ? st_nx : st_q;
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (scan_rst) begin
      st_q <= BSP_TLR;
    end else begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // Instruction register, bypass stage and output stage.
  // Shifter, held instruction, bypass bit, output level and enable.
  logic [`BSP_IR_LEN-1:0] irs_q;
  logic [`BSP_IR_LEN-1:0] irs_d;
  logic [`BSP_IR_LEN-1:0] ir_q;
  logic [`BSP_IR_LEN-1:0] ir_d;
  logic byp_q;
  logic byp_d;
  logic tdo_q;
  logic tdo_d;
  logic oe_q;
  logic oe_d;
  // Decoded data register choice.
  logic sel_bypass;
  // Strobes to the boundary chain.
  logic dr_cap;
  logic dr_shf;
  logic dr_upd;
  // Serial output of the boundary chain.
  logic chain_so;

  // The instruction register is three bits wide, but only bits 2:1 decode,
  // so codes pair up; the sample codes 100/101 act the same as 010/011.
  // two-bit instruction decode, bit 0 ignored
  assign sel_bypass = (ir_q[2:1] == 2'h3);
  assign extest_on = (ir_q[2:1] == 2'h0);
  assign dr_cap = tck_rise & (st_q == BSP_CAP_DR) & ~sel_bypass;
  assign dr_shf = tck_rise & (st_q == BSP_SHF_DR) & ~sel_bypass;
  assign dr_upd = tck_rise & (st_q == BSP_UPD_DR) & ~sel_bypass;

  // Next values of the instruction path and the output stage.
  always_comb begin
    irs_d = irs_q;
    ir_d = ir_q;
    byp_d = byp_q;
    tdo_d = tdo_q;
    oe_d = oe_q;
    if (tck_rise) begin
      case (st_q)
        BSP_TLR: ir_d = `BSP_IR_RESET;
        BSP_CAP_IR: irs_d = `BSP_IR_CAPTURE;
        BSP_SHF_IR: irs_d = {tdi, irs_q[`BSP_IR_LEN-1:1]};
        BSP_UPD_IR: ir_d = irs_q;
        BSP_CAP_DR: byp_d = 1'b0;
        BSP_SHF_DR: byp_d = tdi;
        default: byp_d = byp_q;
      endcase
    end
    if (tck_fall) begin
      case (st_q)
        BSP_SHF_IR: begin
          tdo_d = irs_q[0];
          oe_d = 1'b1;
        end
        BSP_SHF_DR: begin
          tdo_d = sel_bypass ? byp_q : chain_so;
          oe_d = 1'b1;
        end
        default: begin
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // Registers of the instruction path and output stage.
  always_ff @(posedge sys_clk) begin
    if (scan_rst) begin
      irs_q <= `BSP_IR_RESET;
      ir_q <= `BSP_IR_RESET;
      byp_q <= 1'b0;
      tdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      irs_q <= irs_d;
      ir_q <= ir_d;
      byp_q <= byp_d;
      tdo_q <= tdo_d;
      oe_q <= oe_d;
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe = oe_q;

  // ========================================================================
  // Boundary chain; update latches drive pins in external test mode.
  // data steered to chain
  bsp_chain u_chain (
    .sys_clk(sys_clk),
    .scan_rst(scan_rst),
    .capture(dr_cap),
    .shift(dr_shf),
    .update(dr_upd),
    .tdi(tdi),
    .par_in(bsr_pin_in),
    .so(chain_so),
    .upd_q(bsr_cell_out)
  );

endmodule : bsp_tap

// ---- test/bsp_ctl.sv ----
`timescale 1ns/10ps
// ==========================================================================
// Test controller model; its clock stands low between calls.
module bsp_ctl (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tms_drv,
  input wire logic tdi_drv,
  input wire logic tdo,
  input wire logic tdo_oe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // mode applied low
  // Undriven pins toggle, so only the inner pull-up can give a clean one.
  task automatic step(input logic m, input logic d, output logic [1:0] o);
    tms = tms_drv ? m : !tms;
    tdi = tdi_drv ? d : !tdi;
    #40 tck = 1'b1;
    // A disabled driver leaves the line floating; show the inverse so that
    // a bit read while the driver is off cannot pass by luck.
    #39 o = {tdo_oe, tdo_oe ? tdo : !tdo};
    #1 tck = 1'b0;
  endtask : step
endmodule : bsp_ctl

// ---- test/bsp_tap_checker.sv ----
`timescale 1ns/10ps
`include "bsp_consts.svh"
// ==========================================================================
// Port checker: outputs move only shortly after a seen test clock edge.
module bsp_tap_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck_pin,
  input wire logic trst_n_pin,
  input wire logic trst_n_drv,
  input wire logic tdo_o,
  input wire logic tdo_oe,
  input wire logic [`BSP_CHAIN_LEN-1:0] bsr_cell_out,
  input wire logic extest_on
);
  logic [1:0] tck_d, tck_q; // Test clock resampled twice.
  logic [3:0] fall_d, fall_q; // Cycles since the last fall.
  logic [3:0] rise_d, rise_q; // Cycles since the last rise.
  logic hold_rst; // Any reset in force.
  assign hold_rst = rst || (trst_n_drv && !trst_n_pin);
  // Edges are taken one stage early, so no sane design can beat them.
  always_comb begin
    tck_d = {tck_q[0], tck_pin};
    fall_d = fall_q + {3'h0, fall_q != 4'hf};
    rise_d = rise_q + {3'h0, rise_q != 4'hf};
    if (tck_q[1] && !tck_q[0]) begin
      fall_d = 4'h0;
    end
    if (!tck_q[1] && tck_q[0]) begin
      rise_d = 4'h0;
    end
  end
  // Plain registers; they saturate while the test clock stands still.
  always_ff @(posedge sys_clk) begin
    tck_q <= tck_d;
    fall_q <= fall_d;
    rise_q <= rise_d;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (hold_rst);
  trst_clear_a: assert property (disable iff (rst)
    (trst_n_drv && !trst_n_pin)[*6] |-> !tdo_oe && !extest_on
    && bsr_cell_out == '0) else $error("test reset left state behind");
  tdo_edge_a: assert property ($changed(tdo_o) |-> fall_q <= 4'h7)
    else $error("data out moved away from a fall");
  oe_edge_a: assert property ($changed(tdo_oe) |-> fall_q <= 4'h7)
    else $error("driver enable moved away from a fall");
  ext_edge_a: assert property ($changed(extest_on) |-> rise_q <= 4'h7)
    else $error("instruction moved away from a rise");
  upd_edge_a: assert property ($changed(bsr_cell_out) |-> rise_q <= 4'h7)
    else $error("update latch moved away from a rise");
  ext_quiet_a: assert property ($changed(extest_on) |-> !tdo_oe)
    else $error("instruction changed while shifting");
  upd_quiet_a: assert property ($changed(bsr_cell_out) |-> !tdo_oe)
    else $error("latches changed while shifting");
  idle_hold_a: assert property ((fall_q == 4'hf && rise_q == 4'hf)
    |-> $stable(tdo_o) && $stable(bsr_cell_out)) else $error("moved idle");
endmodule : bsp_tap_checker

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`include "bsp_consts.svh"
// ==========================================================================
// Self-checking bench for the test port.
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic tck, tms, tdi, tdo_o, tdo_oe, extest_on;
  logic tms_drv = 1'b1;
  logic tdi_drv = 1'b1;
  logic trst_n = 1'b1;
  logic trst_n_drv = 1'b1;
  logic [117:0] pin_in = '0;
  logic [117:0] cell_out, d, q, exp;
  logic [1:0] o;
  int bad_count = 0;
  int n_compared = 0;
  int seed = 32'h2b5f;
  always #4 sys_clk = ~sys_clk;
  bsp_tap bsp_tap_i (.sys_clk(sys_clk), .rst(rst), .tck_pin(tck),
    .tms_pin(tms), .tms_drv(tms_drv), .tdi_pin(tdi), .tdi_drv(tdi_drv),
    .trst_n_pin(trst_n), .trst_n_drv(trst_n_drv), .tdo_o(tdo_o),
    .tdo_oe(tdo_oe), .bsr_pin_in(pin_in), .bsr_cell_out(cell_out),
    .extest_on(extest_on));
  bsp_ctl bsp_ctl_i (.tck(tck), .tms(tms), .tdi(tdi), .tms_drv(tms_drv),
    .tdi_drv(tdi_drv), .tdo(tdo_o), .tdo_oe(tdo_oe));
  function automatic logic [117:0] rnd();
    rnd = 118'({$random(seed), $random(seed), $random(seed), $random(seed)});
  endfunction : rnd
  task automatic check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : check
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  // One scan from idle back to idle; bit i leaves on step i.
  task automatic scan(input logic ir, input int n, input logic [117:0] v);
    q = '0;
    bsp_ctl_i.step(1'b1, 1'b0, o);
    if (ir) begin
      bsp_ctl_i.step(1'b1, 1'b0, o);
    end
    bsp_ctl_i.step(1'b0, 1'b0, o);
    bsp_ctl_i.step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      bsp_ctl_i.step(i == n - 1, v[i], o);
      q[i] = o[0];
      check(o[1], "driver off in shift");
    end
    bsp_ctl_i.step(1'b1, 1'b0, o);
    check(o[1] === 1'b0, "driver on after shift");
    bsp_ctl_i.step(1'b0, 1'b0, o);
  endtask : scan
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    check(extest_on === 1'b0, "not bypass after reset");
    bsp_ctl_i.step(1'b0, 1'b0, o);
    // Reset must leave the one-stage bypass path selected.
    d = rnd();
    scan(1'b0, 8, d);
    check(q === 118'({d[6:0], 1'b0}), "no bypass after reset");
    // Every code, then a data scan over the register it selects.
    for (int c = 0; c < 8; c++) begin
      @(negedge sys_clk) pin_in = rnd();
      scan(1'b1, 3, 118'(c));
      check(q[2:0] === 3'h1, "instruction capture");
      check(extest_on === (c < 2), "instruction decode");
      d = rnd();
      scan(1'b0, (c > 5) ? 8 : 118, d);
      exp = (c > 5) ? 118'({d[6:0], 1'b0}) : pin_in;
      check(q === exp, "data path out");
      if (c < 6) begin
        check(cell_out === d, "update latches");
      end
    end
    // Undriven mode select reads high and walks to test reset state.
    scan(1'b1, 3, '0);
    tms_drv = 1'b0;
    tdi_drv = 1'b0;
    repeat (5) bsp_ctl_i.step(1'b0, 1'b0, o);
    check(extest_on === 1'b0, "undriven mode not high");
    tms_drv = 1'b1;
    tdi_drv = 1'b1;
    bsp_ctl_i.step(1'b0, 1'b0, o);
    scan(1'b1, 3, '0);
    d = rnd();
    scan(1'b0, 118, d);
    // An undriven low reset pin is ignored; a driven one clears all.
    @(negedge sys_clk) trst_n_drv = 1'b0;
    trst_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    check(extest_on === 1'b1, "undriven reset acted");
    trst_n_drv = 1'b1;
    repeat (10) @(negedge sys_clk);
    check(extest_on === 1'b0 && cell_out === '0, "reset left");
    check(tdo_oe === 1'b0, "driver on in reset");
    trst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    // Test reset must also bring back the bypass path.
    bsp_ctl_i.step(1'b0, 1'b0, o);
    d = rnd();
    scan(1'b0, 8, d);
    check(q === 118'({d[6:0], 1'b0}), "no bypass after trst");
    final_report();
  end
endmodule : testbench
bind bsp_tap bsp_tap_checker bsp_tap_checker_i (.sys_clk(sys_clk),
  .rst(rst), .tck_pin(tck_pin), .trst_n_pin(trst_n_pin),
  .trst_n_drv(trst_n_drv), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
  .bsr_cell_out(bsr_cell_out), .extest_on(extest_on));
